// [rtl/spr_ctrl.sv]
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) Select field picks six modes, two reserved
// (RULE_02) Sleep instruction sleeps only when armed
// (RULE_03) Software arms just before, disarms after
// (RULE_04) Timed two-write unlock sets brown-out off
// (RULE_05) Brown-out off active three cycles later
// (RULE_06) Brown-out off self-clears after three cycles
// (RULE_07) Detector off only if sleep while active
// (RULE_08) Brown-out bits at six and five
// (RULE_09) Bit seven gates two-wire clock
// (RULE_10) Bit six gates timer two if synchronous
// (RULE_11) Bits five, three gate timers zero, one
// (RULE_12) Bits four, one gate both serial ports
// (RULE_13) Bit two gates the SPI clock
// (RULE_14) Bit zero gates converter, blocks comparator mux
// (RULE_15) Software disables converter before gating it
// (RULE_16) Enabled converter stays on; restart is extended
// (RULE_17) Deep sleep disables comparator unless reference
// (RULE_18) Deep sleep disables input buffers except wake
// (RULE_19) Debug enabled keeps main clock in sleep
// (RULE_20) Debug disable bit or fuses kill debug
// (RULE_21) Watchdog and fused detector run in sleep
// (RULE_22) Wake by interrupt halts four extra cycles
// (RULE_23) Gated peripheral frozen, registers inaccessible
// (RULE_24) Ungating returns peripheral to prior state
// (RULE_25) Reserved select code never enters sleep
module spr_ctrl
    import spr_pkg::*;
#(
    parameter int STARTUP_CYC = SPR_STARTUP_CYC
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // CPU and system inputs
    input  wire logic        sleep_instr_i,
    input  wire logic        wake_irq_i,
    input  wire logic        timer_two_async_select_i,
    input  wire logic        converter_enable_i,
    input  wire logic        comparator_uses_ref_i,
    input  wire logic        debug_fuse_i,
    input  wire logic        test_port_fuse_i,
    input  wire logic        brownout_fuse_en_i,
    input  wire logic        watchdog_en_i,
    // Outputs
    output spr_clk_en_t      periph_clk_en_o,
    output spr_power_t       power_o,
    output logic             cpu_halt_o,
    output logic             sleeping_o,
    output logic             brownout_run_o,
    output logic             watchdog_run_o,
    output logic             comparator_mux_ok_o
);

    // Saturating decrement for the unlock window counter
    function automatic logic [2:0] dec3(input logic [2:0] v);
        dec3 = (v == 3'h0) ? 3'h0 : v - 3'h1;
    endfunction

    // Mode is deep when the I/O clocks stop; the converter clock follows its gate bit alone
    function automatic logic deep_mode(input logic [2:0] s);
        deep_mode = (s == SPR_SEL_PDOWN) || (s == SPR_SEL_PSAVE) ||
                    (s == SPR_SEL_STANDBY) || (s == SPR_SEL_EXT_STBY);
    endfunction

    logic [7:0]  mcu_q, mcu_d;
    logic [7:0]  sleep_ctl_q, sleep_ctl_d;
    logic [7:0]  gate_q, gate_d;
    logic [2:0]  unlock_q, unlock_d;
    logic [2:0]  bod_age_q, bod_age_d;
    logic        bod_sleep_q, bod_sleep_d;
    logic [2:0]  mode_q, mode_d;
    logic [7:0]  wait_q, wait_d;
    logic        conv_was_on_q;
    logic        conv_ext_q, conv_ext_d;
    spr_state_t  state_q, state_d;
    logic [31:0] rdata_d;

    // APB decode: zero-wait access phase
    wire         acc      = psel_i & penable_i;
    wire         wr       = acc & pwrite_i;
    wire         hit_mcu  = paddr_i[9:0] == SPR_ADDR_MCU_CONTROL;
    wire         hit_gate = paddr_i[9:0] == SPR_ADDR_PERIPH_GATE;
    wire         hit_slp  = paddr_i[9:0] == SPR_ADDR_SLEEP_CONTROL;
    wire         hit_stat = paddr_i[9:0] == SPR_ADDR_STATUS;
    wire         hit_any  = (hit_mcu | hit_gate | hit_slp | hit_stat) & (paddr_i[11:10] == 2'b00);
    wire [7:0]   wbyte    = pwdata_i[7:0];
    wire         wr_mcu   = wr & hit_mcu & hit_any;

    // (RULE_01) Mode field decode
    wire [2:0]   sel      = sleep_ctl_q[SPR_SC_SEL_HI:SPR_SC_SEL_LO];
    // (RULE_25) Reserved codes rejected
    wire         sel_ok   = (sel != SPR_SEL_RSVD_A) && (sel != SPR_SEL_RSVD_B);
    // (RULE_02) Sleep only when armed
    wire         go_sleep = sleep_instr_i & sleep_ctl_q[SPR_SC_ARM] & sel_ok &
                            (state_q == SPR_ST_RUN);

    // (RULE_04) Unlock write opens the window; second write inside it sets the bit
    wire         unlock_wr = wr_mcu & wbyte[SPR_MC_BOD_OFF] & wbyte[SPR_MC_BOD_UNLOCK];
    wire         commit_wr = wr_mcu & wbyte[SPR_MC_BOD_OFF] & ~wbyte[SPR_MC_BOD_UNLOCK] &
                             (unlock_q != 3'h0);

    // (RULE_20) Debug off by bit or either fuse cleared
    wire         debug_on = debug_fuse_i & test_port_fuse_i & ~mcu_q[SPR_MC_DEBUG_DISABLE];
    // (RULE_05) Active from three cycles after set until self-clear
    wire         bod_active = bod_sleep_q & (bod_age_q >= 3'(SPR_BOD_ACTIVE_CYC));

    // Register writes, unlock bit self-clears with the window
    always_comb begin
        mcu_d = mcu_q;
        if (wr_mcu) begin
            mcu_d = (mcu_q & ~SPR_MC_PLAIN_MASK) | (wbyte & SPR_MC_PLAIN_MASK);
            mcu_d[SPR_MC_BOD_UNLOCK] = wbyte[SPR_MC_BOD_UNLOCK];
        end else if (unlock_q == 3'h1) begin
            mcu_d[SPR_MC_BOD_UNLOCK] = 1'b0;
        end
        // (RULE_08) Brown-out off bit mirrors the timed flag
        mcu_d[SPR_MC_BOD_OFF] = bod_sleep_d;
    end

    // (RULE_04) Four-cycle unlock window
    always_comb begin
        unlock_d = dec3(unlock_q);
        if (unlock_wr) begin
            unlock_d = 3'(SPR_UNLOCK_WINDOW_CYC);
        end else if (commit_wr) begin
            unlock_d = 3'h0;
        end
    end

    // (RULE_06) Self-clear three cycles after becoming active
    always_comb begin
        bod_sleep_d = bod_sleep_q;
        bod_age_d   = bod_age_q;
        if (commit_wr) begin
            bod_sleep_d = 1'b1;
            bod_age_d   = 3'h0;
        end else if (bod_sleep_q) begin
            if (bod_age_q == 3'(SPR_BOD_ACTIVE_CYC + SPR_BOD_CLEAR_CYC - 1)) begin
                bod_sleep_d = 1'b0;
                bod_age_d   = 3'h0;
            end else begin
                bod_age_d = bod_age_q + 3'h1;
            end
        end
    end

    // Sleep sequencer: run, sleep, startup, halt
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        wait_d  = (wait_q == 8'h00) ? 8'h00 : wait_q - 8'h01;
        case (state_q)
            SPR_ST_RUN: begin
                if (go_sleep) begin
                    state_d = SPR_ST_SLEEP;
                    mode_d  = sel;
                end
            end
            SPR_ST_SLEEP: begin
                if (wake_irq_i) begin
                    state_d = SPR_ST_STARTUP;
                    wait_d  = 8'(STARTUP_CYC);
                end
            end
            SPR_ST_STARTUP: begin
                if (wait_q == 8'h01) begin
                    // (RULE_22) Four extra halt cycles
                    state_d = SPR_ST_HALT;
                    wait_d  = 8'(SPR_WAKE_HALT_CYC);
                end
            end
            SPR_ST_HALT: begin
                if (wait_q == 8'h01) begin
                    state_d = SPR_ST_RUN;
                end
            end
            default: state_d = SPR_ST_RUN;
        endcase
    end

    // Next-state view so sleep controls move with sleeping_o
    wire asleep = (state_d == SPR_ST_SLEEP);
    wire deep   = asleep & deep_mode(mode_d);
    logic bod_cut_q, bod_cut_d;

    // (RULE_07) Cut detector only if sleep entered while bit active
    always_comb begin
        bod_cut_d = bod_cut_q;
        if (go_sleep) begin
            bod_cut_d = bod_active & deep_mode(sel);
        end else if (state_d != SPR_ST_SLEEP) begin
            // Detector back on in the same cycle sleep ends
            bod_cut_d = 1'b0;
        end
    end

    // (RULE_16) Off-then-on converter makes next conversion extended
    always_comb begin
        conv_ext_d = conv_ext_q;
        if (converter_enable_i & ~gate_q[SPR_PG_CONVERTER] & ~conv_was_on_q) begin
            conv_ext_d = 1'b1;
        end else if (~converter_enable_i) begin
            conv_ext_d = 1'b0;
        end
    end

    // Read mux, unmapped reads zero with error
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_mcu) begin
            rdata_d[7:0] = mcu_q;
        end else if (hit_gate) begin
            rdata_d[7:0] = gate_q;
        end else if (hit_slp) begin
            rdata_d[7:0] = sleep_ctl_q;
        end else if (hit_stat) begin
            rdata_d[7:0] = {4'h0, bod_active, mode_q};
        end
    end

    assign sleep_ctl_d = (wr & hit_slp & hit_any) ? {4'h0, wbyte[3:0]} : sleep_ctl_q;
    assign gate_d      = (wr & hit_gate & hit_any) ? wbyte : gate_q;

    // Control and state registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mcu_q       <= SPR_RST_MCU_CONTROL;
            sleep_ctl_q <= SPR_RST_SLEEP_CONTROL;
            gate_q      <= SPR_RST_PERIPH_GATE;
            unlock_q    <= 3'h0;
            bod_sleep_q <= 1'b0;
            bod_age_q   <= 3'h0;
            bod_cut_q   <= 1'b0;
            state_q     <= SPR_ST_RUN;
            mode_q      <= SPR_SEL_IDLE;
            wait_q      <= 8'h00;
        end else if (clk_en_i) begin
            mcu_q       <= mcu_d;
            sleep_ctl_q <= sleep_ctl_d;
            gate_q      <= gate_d;
            unlock_q    <= unlock_d;
            bod_sleep_q <= bod_sleep_d;
            bod_age_q   <= bod_age_d;
            bod_cut_q   <= bod_cut_d;
            state_q     <= state_d;
            mode_q      <= mode_d;
            wait_q      <= wait_d;
        end
    end

    // Converter history, used for the extended-conversion flag
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            conv_was_on_q <= 1'b0;
            conv_ext_q    <= 1'b0;
        end else if (clk_en_i) begin
            conv_was_on_q <= converter_enable_i & ~gate_q[SPR_PG_CONVERTER];
            conv_ext_q    <= conv_ext_d;
        end
    end

    // Clock enables: gating stops the clock only, so state is kept
    // (RULE_23) Gated peripheral clock frozen
    // (RULE_24) Ungating resumes prior state
    spr_clk_en_t clk_en_d;
    always_comb begin
        // (RULE_09) Two-wire gate
        clk_en_d.two_wire    = ~gate_q[SPR_PG_TWO_WIRE] & ~deep;
        // (RULE_10) Timer two gated only in synchronous mode
        clk_en_d.timer_two   = (~gate_q[SPR_PG_TIMER_TWO] & ~deep) | timer_two_async_select_i;
        // (RULE_11) Timer zero and one gates
        clk_en_d.timer_zero  = ~gate_q[SPR_PG_TIMER_ZERO] & ~deep;
        clk_en_d.timer_one   = ~gate_q[SPR_PG_TIMER_ONE] & ~deep;
        // (RULE_12) Serial port gates
        clk_en_d.serial_one  = ~gate_q[SPR_PG_SERIAL_ONE] & ~deep;
        clk_en_d.serial_zero = ~gate_q[SPR_PG_SERIAL_ZERO] & ~deep;
        // (RULE_13) SPI gate
        clk_en_d.spi         = ~gate_q[SPR_PG_SPI] & ~deep;
        // (RULE_14) Converter gate
        clk_en_d.converter   = ~gate_q[SPR_PG_CONVERTER];
    end

    // Sleep-time power controls
    spr_power_t pwr_d;
    always_comb begin
        pwr_d.bod_off            = bod_cut_d;
        // (RULE_17) Comparator off in deep modes unless on reference
        pwr_d.comparator_off     = deep & ~comparator_uses_ref_i;
        pwr_d.reference_keep     = deep & comparator_uses_ref_i;
        // (RULE_18) Input buffers off in deep modes
        pwr_d.input_buf_off      = deep;
        // (RULE_19) Debug keeps main clock
        pwr_d.main_clk_keep      = debug_on;
        // (RULE_16) Enabled converter stays on in sleep
        pwr_d.converter_on       = converter_enable_i & ~gate_q[SPR_PG_CONVERTER];
        pwr_d.converter_extended = conv_ext_d;
        pwr_d.debug_enable       = debug_on;
    end

    // Registered outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prdata_o            <= 32'h0000_0000;
            pready_o            <= 1'b0;
            pslverr_o           <= 1'b0;
            periph_clk_en_o     <= '1;
            power_o             <= '0;
            cpu_halt_o          <= 1'b0;
            sleeping_o          <= 1'b0;
            brownout_run_o      <= 1'b0;
            watchdog_run_o      <= 1'b0;
            comparator_mux_ok_o <= 1'b1;
        end else if (clk_en_i) begin
            // One-cycle ready pulse one edge after the setup phase
            pready_o            <= psel_i & ~penable_i;
            pslverr_o           <= psel_i & ~penable_i & ~hit_any;
            prdata_o            <= hit_any ? rdata_d : 32'h0000_0000;
            periph_clk_en_o     <= clk_en_d;
            power_o             <= pwr_d;
            cpu_halt_o          <= state_d != SPR_ST_RUN;
            sleeping_o          <= state_d == SPR_ST_SLEEP;
            // (RULE_21) Fused detector and watchdog keep running
            brownout_run_o      <= brownout_fuse_en_i & ~bod_cut_d;
            watchdog_run_o      <= watchdog_en_i;
            // (RULE_14) Comparator loses converter mux when gated
            comparator_mux_ok_o <= ~gate_q[SPR_PG_CONVERTER];
        end
    end

endmodule // spr_ctrl

// [rtl/spr_pkg.sv]
package spr_pkg;

    // Register byte addresses (printed offsets are not all multiples of four: index * 4)
    localparam logic [7:0] SPR_IDX_MCU_CONTROL   = 8'h35;
    localparam logic [7:0] SPR_IDX_PERIPH_GATE   = 8'h64;
    localparam logic [7:0] SPR_IDX_SLEEP_CONTROL = 8'h36;
    localparam logic [7:0] SPR_IDX_STATUS        = 8'h37;
    localparam logic [9:0] SPR_ADDR_MCU_CONTROL   = {SPR_IDX_MCU_CONTROL, 2'b00};
    localparam logic [9:0] SPR_ADDR_PERIPH_GATE   = {SPR_IDX_PERIPH_GATE, 2'b00};
    localparam logic [9:0] SPR_ADDR_SLEEP_CONTROL = {SPR_IDX_SLEEP_CONTROL, 2'b00};
    localparam logic [9:0] SPR_ADDR_STATUS        = {SPR_IDX_STATUS, 2'b00};

    // Reset values
    localparam logic [7:0] SPR_RST_MCU_CONTROL   = 8'h00;
    localparam logic [7:0] SPR_RST_PERIPH_GATE   = 8'h00;
    localparam logic [7:0] SPR_RST_SLEEP_CONTROL = 8'h00;

    // mcu_control fields
    localparam int SPR_MC_DEBUG_DISABLE = 7;
    localparam int SPR_MC_BOD_OFF       = 6;
    localparam int SPR_MC_BOD_UNLOCK    = 5;
    localparam logic [7:0] SPR_MC_PLAIN_MASK = 8'h93;  // bits 7,4,1,0 plain storage

    // sleep_mode_control fields
    localparam int SPR_SC_SEL_HI = 3;
    localparam int SPR_SC_SEL_LO = 1;
    localparam int SPR_SC_ARM    = 0;

    // peripheral_clock_gate fields
    localparam int SPR_PG_TWO_WIRE   = 7;
    localparam int SPR_PG_TIMER_TWO  = 6;
    localparam int SPR_PG_TIMER_ZERO = 5;
    localparam int SPR_PG_SERIAL_ONE = 4;
    localparam int SPR_PG_TIMER_ONE  = 3;
    localparam int SPR_PG_SPI        = 2;
    localparam int SPR_PG_SERIAL_ZERO = 1;
    localparam int SPR_PG_CONVERTER  = 0;

    // Sleep select codes
    localparam logic [2:0] SPR_SEL_IDLE     = 3'h0;
    localparam logic [2:0] SPR_SEL_ADC_NR   = 3'h1;
    localparam logic [2:0] SPR_SEL_PDOWN    = 3'h2;
    localparam logic [2:0] SPR_SEL_PSAVE    = 3'h3;
    localparam logic [2:0] SPR_SEL_RSVD_A   = 3'h4;
    localparam logic [2:0] SPR_SEL_RSVD_B   = 3'h5;
    localparam logic [2:0] SPR_SEL_STANDBY  = 3'h6;
    localparam logic [2:0] SPR_SEL_EXT_STBY = 3'h7;

    // Timing, in CPU clock cycles
    localparam int SPR_UNLOCK_WINDOW_CYC = 4;
    localparam int SPR_BOD_ACTIVE_CYC    = 3;
    localparam int SPR_BOD_CLEAR_CYC     = 3;
    localparam int SPR_WAKE_HALT_CYC     = 4;
    localparam int SPR_STARTUP_CYC       = 16;

    // Sleep sequencer states
    typedef enum logic [1:0] {
        SPR_ST_RUN,
        SPR_ST_SLEEP,
        SPR_ST_STARTUP,
        SPR_ST_HALT
    } spr_state_t;

    // Sleep-time controls to the analog, clock and pad logic
    typedef struct packed {
        logic bod_off;
        logic comparator_off;
        logic reference_keep;
        logic input_buf_off;
        logic main_clk_keep;
        logic converter_on;
        logic converter_extended;
        logic debug_enable;
    } spr_power_t;

    // Per-peripheral clock enables
    typedef struct packed {
        logic two_wire;
        logic timer_two;
        logic timer_zero;
        logic serial_one;
        logic timer_one;
        logic spi;
        logic serial_zero;
        logic converter;
    } spr_clk_en_t;

endpackage

// [test/spr_ctrl_checker.sv]
`timescale 1ns/1ps
// Port-level watcher for the sleep and clock-gate controller
module spr_ctrl_checker
    import spr_pkg::*;
#(
    parameter int STARTUP_CYC = SPR_STARTUP_CYC
) (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Bus side
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // System side
    input wire logic        sleep_instr_i,
    input wire logic        watchdog_en_i,
    input wire logic        debug_fuse_i,
    input wire logic        test_port_fuse_i,
    input wire spr_clk_en_t periph_clk_en_o,
    input wire spr_power_t  power_o,
    input wire logic        cpu_halt_o,
    input wire logic        sleeping_o,
    input wire logic        brownout_run_o,
    input wire logic        watchdog_run_o,
    input wire logic        comparator_mux_ok_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Decoded register hit, mirrors the four mapped words
    wire mapped = (paddr_i == {2'b00, SPR_ADDR_MCU_CONTROL}) ||
                  (paddr_i == {2'b00, SPR_ADDR_SLEEP_CONTROL}) ||
                  (paddr_i == {2'b00, SPR_ADDR_STATUS}) ||
                  (paddr_i == {2'b00, SPR_ADDR_PERIPH_GATE});

    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    a_ready_one_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error flag wrong for address");
    a_mux_blocked: assert property (comparator_mux_ok_o == periph_clk_en_o.converter)
        else $error("comparator mux not tied to converter gate");
    a_sleep_cause: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
        else $error("sleep entered without instruction");
    a_halt_in_sleep: assert property (sleeping_o |-> cpu_halt_o)
        else $error("cpu running while asleep");
    a_wake_halt_len: assert property ($fell(sleeping_o) |-> cpu_halt_o [*7] ##[1:5] !cpu_halt_o)
        else $error("wake halt length wrong");
    a_bod_cut: assert property (power_o.bod_off |-> sleeping_o && !brownout_run_o)
        else $error("detector cut outside sleep");
    a_deep_only: assert property (power_o.input_buf_off || power_o.comparator_off |-> sleeping_o)
        else $error("deep sleep control while awake");
    a_watchdog_run: assert property (!$past(rst_i) |-> watchdog_run_o == $past(watchdog_en_i))
        else $error("watchdog run does not follow enable");
    a_debug_fuses: assert property (power_o.debug_enable |-> $past(debug_fuse_i) && $past(test_port_fuse_i))
        else $error("debug enabled without fuses");
    a_debug_clock: assert property (sleeping_o && power_o.debug_enable |-> power_o.main_clk_keep)
        else $error("main clock dropped with debug on");
endmodule // spr_ctrl_checker

// [test/spr_ctrl_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end
module spr_ctrl_tb;
    import spr_pkg::*;
    localparam int SC = 4;
    logic clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, sleep_i = 0, wake = 0;
    logic async_i = 0, wdog = 0, dbg = 0, bfuse = 1, conv = 1, cref = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, e, cpu_halt_o, sleeping_o, brownout_run_o, watchdog_run_o, mux_ok;
    spr_clk_en_t periph_clk_en_o;
    spr_power_t  power_o;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    spr_ctrl #(.STARTUP_CYC(SC)) spr_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i),
        .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sleep_instr_i(sleep_i), .wake_irq_i(wake),
        .timer_two_async_select_i(async_i), .converter_enable_i(conv),
        .comparator_uses_ref_i(cref), .debug_fuse_i(dbg), .test_port_fuse_i(1'b1),
        .brownout_fuse_en_i(bfuse), .watchdog_en_i(wdog), .periph_clk_en_o(periph_clk_en_o),
        .power_o(power_o), .cpu_halt_o(cpu_halt_o), .sleeping_o(sleeping_o),
        .brownout_run_o(brownout_run_o), .watchdog_run_o(watchdog_run_o),
        .comparator_mux_ok_o(mux_ok));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // One APB transfer, held until ready is seen at an edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock_i);
        penable <= 1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        // A transfer that never completes counts as a failure
        if (pready !== 1'b1) n_mismatch++;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock_i);
    endtask
    // Wake by interrupt; halt must span start-up plus four cycles
    task automatic wake_up();
        int n;
        n = 0;
        wake <= 1;
        do begin
            @(posedge clock_i);
            n++;
        end while (cpu_halt_o !== 1'b0 && n < 100);
        wake <= 0;
        // Start-up plus four halt cycles, one edge to see wake, one to see the fall
        `CHK(n, SC + SPR_WAKE_HALT_CYC + 2)
    endtask
    task automatic sleep_pulse();
        @(posedge clock_i);
        sleep_i <= 1;
        @(posedge clock_i);
        sleep_i <= 0;
        settle();
    endtask

    task automatic t_reset();
        rd({2'b00, SPR_ADDR_MCU_CONTROL});
        `CHK(r, 32'h0)
        rd({2'b00, SPR_ADDR_PERIPH_GATE});
        `CHK(r, 32'h0)
        rd({2'b00, SPR_ADDR_SLEEP_CONTROL});
        `CHK(r, 32'h0)
        `CHK(periph_clk_en_o, spr_clk_en_t'(8'hFF))
        rd(12'h0E0);
        `CHK({r, e}, {32'h0, 1'b1})
        $display("test reset done");
    endtask

    task automatic t_gate();
        conv <= 0;
        for (int i = 0; i < 8; i++) begin
            wr({2'b00, SPR_ADDR_PERIPH_GATE}, 32'(8'h01 << i));
            settle();
            `CHK(periph_clk_en_o, spr_clk_en_t'(8'hFF ^ (8'h01 << i)))
            `CHK(mux_ok, i != 0)
            rd({2'b00, SPR_ADDR_PERIPH_GATE});
            `CHK(r, 32'(8'h01 << i))
        end
        `CHK(power_o.converter_extended, 1'b0)
        async_i <= 1;
        wr({2'b00, SPR_ADDR_PERIPH_GATE}, 32'h40);
        settle();
        `CHK(periph_clk_en_o.timer_two, 1'b1)
        wr({2'b00, SPR_ADDR_PERIPH_GATE}, 32'h0);
        async_i <= 0;
        conv <= 1;
        settle();
        `CHK(periph_clk_en_o, spr_clk_en_t'(8'hFF))
        `CHK(power_o.converter_extended, 1'b1)
        $display("test gate done");
    endtask

    task automatic t_sleep();
        logic ok;
        dbg <= 1;
        for (int c = 0; c < 8; c++) begin
            // Software arms right before the instruction
            cref <= c[0];
            wr({2'b00, SPR_ADDR_SLEEP_CONTROL}, {28'h0, 3'(c), 1'b1});
            sleep_pulse();
            ok = (c != 4) && (c != 5);
            `CHK(sleeping_o, ok)
            `CHK(power_o.input_buf_off, ok && c[1])
            `CHK(power_o.comparator_off, ok && c[1] && !c[0])
            `CHK(power_o.reference_keep, ok && c[1] && c[0])
            `CHK(power_o.main_clk_keep, 1'b1)
            `CHK(power_o.converter_on, 1'b1)
            if (ok) begin
                rd({2'b00, SPR_ADDR_STATUS});
                `CHK(r[2:0], 3'(c))
                wake_up();
            end
        end
        wr({2'b00, SPR_ADDR_SLEEP_CONTROL}, 32'h4);
        sleep_pulse();
        `CHK(sleeping_o, 1'b0)
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h80);
        settle();
        `CHK(power_o.debug_enable, 1'b0)
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h0);
        settle();
        `CHK(power_o.debug_enable, 1'b1)
        dbg <= 0;
        $display("test sleep done");
    endtask

    task automatic t_bod();
        wdog <= 1;
        wr({2'b00, SPR_ADDR_SLEEP_CONTROL}, 32'h5);
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h60);
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h40);
        rd({2'b00, SPR_ADDR_MCU_CONTROL});
        `CHK(r, 32'h40)
        repeat (8) @(posedge clock_i);
        rd({2'b00, SPR_ADDR_MCU_CONTROL});
        `CHK(r, 32'h0)
        `CHK({brownout_run_o, watchdog_run_o}, 2'b11)
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h60);
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h40);
        // Bit is only active from its fourth cycle on
        repeat (3) @(posedge clock_i);
        sleep_i <= 1;
        @(posedge clock_i);
        sleep_i <= 0;
        settle();
        `CHK({power_o.bod_off, brownout_run_o}, 2'b10)
        wake_up();
        settle();
        `CHK({power_o.bod_off, brownout_run_o}, 2'b01)
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h60);
        repeat (6) @(posedge clock_i);
        wr({2'b00, SPR_ADDR_MCU_CONTROL}, 32'h40);
        rd({2'b00, SPR_ADDR_MCU_CONTROL});
        `CHK(r[6], 1'b0)
        sleep_pulse();
        `CHK({sleeping_o, power_o.bod_off}, 2'b10)
        wake_up();
        $display("test brownout done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 0;
        t_reset();
        t_gate();
        t_sleep();
        t_bod();
        finish_test();
    end
endmodule // spr_ctrl_tb

bind spr_ctrl spr_ctrl_checker #(.STARTUP_CYC(STARTUP_CYC)) spr_ctrl_checker_inst (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleep_instr_i(sleep_instr_i), .watchdog_en_i(watchdog_en_i),
    .debug_fuse_i(debug_fuse_i), .test_port_fuse_i(test_port_fuse_i),
    .periph_clk_en_o(periph_clk_en_o), .power_o(power_o), .cpu_halt_o(cpu_halt_o),
    .sleeping_o(sleeping_o), .brownout_run_o(brownout_run_o),
    .watchdog_run_o(watchdog_run_o), .comparator_mux_ok_o(comparator_mux_ok_o));
